/* File: verilog/paged_address_and_stack_agu.sv */
// Paged effective address generator with software stack pointer and APB registers
//
// The implementer's own choices: the register addresses and the APB slave port.
`include "agu_map.svh"

module paged_address_and_stack_agu (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              agu_req,
  input  wire logic              agu_write,
  input  agu_pkg::agu_mode_e     agu_mode,
  input  wire logic [15:0]       agu_base,
  input  wire logic [15:0]       agu_offset,
  input  wire logic              agu_is_stack,
  input  wire logic              agu_is_frame,
  output logic                   ea_valid,
  output logic [15:0]            effective_address,
  output logic [15:0]            updated_base,
  output logic [9:0]             ea_page,
  output logic                   addr_trap,
  input  wire logic              default_work_reg_we,
  input  wire logic [3:0]        default_work_reg_sel,
  input  wire logic [15:0]       default_work_reg_wdata,
  output logic [15:0]            stack_pointer_reg,
  input  agu_pkg::stk_op_e       stk_op,
  input  wire logic [15:0]       stk_data,
  input  wire logic [22:0]       pc,
  input  wire logic [7:0]        status_low_byte,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic [15:0]            mem_addr,
  output logic [15:0]            mem_wdata,
  output logic                   stk_busy,
  input  wire logic              file_req,
  input  wire logic [12:0]       file_addr,
  output logic [15:0]            near_addr,
  output logic [3:0]             file_wsel,
  input  wire logic              op2_lit_sel,
  input  wire logic [4:0]        op2_lit,
  input  wire logic [15:0]       op2_reg_val,
  output logic [15:0]            op2_value
);
  import agu_pkg::*;

  logic [9:0]  read_page_reg;
  logic [9:0]  write_page_reg;
  logic [15:0] frame_pointer_reg;
  logic        frame_active_flag;
  logic [1:0]  trap_stat_reg;
  stk_state_e  stk_state_reg;
  logic [15:0] hold_word_reg;

  logic        apb_write;
  logic        apb_read;
  logic [9:0]  active_page_reg;
  logic        paged;
  logic        linear;
  logic        nonpaged_mode;
  logic [16:0] sum;
  logic [9:0]  new_page;
  logic        ea15;
  logic        ovf;
  logic        udf;
  logic        trap_zero;
  logic        trap_psw;
  logic        page_upd;
  logic [15:0] mod_addr;
  logic        stk_start;
  logic        sp_by_default_work_reg;
  logic        fp_by_default_work_reg;

  // Known register offsets, used by the error answer; the read mux decodes them itself
  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a == `OFS_READ_PAGE) || (a == `OFS_WRITE_PAGE) ||
                (a == `OFS_STACK_PTR) || (a == `OFS_FRAME_PTR) ||
                (a == `OFS_CONTROL)   || (a == `OFS_TRAP_STAT);
  endfunction

  // Bus transfer completes on the second access cycle
  assign apb_write = psel & penable & pready & pwrite;
  assign apb_read  = psel & penable & ~pready & ~pwrite;

  // Stack pointer and active frame pointer bypass paging entirely
  assign nonpaged_mode = agu_is_stack | (agu_is_frame & frame_active_flag);
  assign active_page_reg = agu_write ? write_page_reg : read_page_reg;
  assign paged = agu_base[15] & ~nonpaged_mode & (agu_mode != MODE_DIRECT);
  assign linear = (agu_mode == MODE_POST) | (agu_mode == MODE_PRE);
  assign sum = {1'b0, agu_base} + {agu_offset[15], agu_offset};
  assign trap_zero = agu_req & paged & (active_page_reg == `PG_ZERO);
  assign trap_psw  = agu_req & paged & agu_write & write_page_reg[`PG_PSV_BIT];
  assign page_upd  = agu_req & paged & linear & ~trap_zero & ~trap_psw;
  assign mod_addr  = paged ? {ea15, sum[14:0]} : sum[15:0];

  page_boundary_fix u_fix (
    .page       (active_page_reg),
    .sum        (sum),
    .offset_neg (agu_offset[15]),
    .is_write   (agu_write),
    .linear     (linear),
    .new_page   (new_page),
    .ea15       (ea15),
    .ovf        (ovf),
    .udf        (udf)
  );

  // Bus answer: one wait cycle keeps read data and ready both registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~reg_known(paddr);
      if (apb_read) begin
        unique case (paddr)
          `OFS_READ_PAGE:  prdata <= {22'h000000, read_page_reg};
          `OFS_WRITE_PAGE: prdata <= {22'h000000, write_page_reg};
          `OFS_STACK_PTR:  prdata <= {16'h0000, stack_pointer_reg};
          `OFS_FRAME_PTR:  prdata <= {16'h0000, frame_pointer_reg};
          `OFS_CONTROL:    prdata <= {31'h00000000, frame_active_flag};
          `OFS_TRAP_STAT:  prdata <= {30'h00000000, trap_stat_reg};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Page registers: hardware carry wins over a bus write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_page_reg  <= `PAGE_RESET;
      write_page_reg <= `PAGE_RESET;
    end else if (page_upd) begin
      if (agu_write) begin
        write_page_reg <= new_page;
      end else begin
        read_page_reg <= new_page;
      end
    end else if (apb_write) begin
      if (paddr == `OFS_READ_PAGE) begin
        read_page_reg <= pwdata[9:0];
      end
      if (paddr == `OFS_WRITE_PAGE) begin
        write_page_reg <= pwdata[9:0];
      end
    end
  end

  // Control flag and sticky trap flags; a new trap beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_active_flag <= 1'b0;
      trap_stat_reg     <= 2'b00;
    end else begin
      if (apb_write && paddr == `OFS_CONTROL) begin
        frame_active_flag <= pwdata[`CTRL_FRAME_BIT];
      end
      for (int i = 0; i < 2; i++) begin
        if ((i == `TRAP_ZERO_BIT && trap_zero) || (i == `TRAP_PSW_BIT && trap_psw)) begin
          trap_stat_reg[i] <= 1'b1;
        end else if (apb_write && paddr == `OFS_TRAP_STAT && pwdata[i]) begin
          trap_stat_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Effective address result, one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ea_valid          <= 1'b0;
      addr_trap         <= 1'b0;
      effective_address <= 16'h0000;
      updated_base      <= 16'h0000;
      ea_page           <= `PG_ZERO;
    end else begin
      ea_valid  <= agu_req & ~trap_zero & ~trap_psw;
      addr_trap <= trap_zero | trap_psw;
      if (agu_req) begin
        // Page reported with the access forms the extended address
        ea_page <= paged ? active_page_reg : `PG_ZERO;
        unique case (agu_mode)
          MODE_POST: begin
            effective_address <= agu_base;
            updated_base      <= mod_addr;
          end
          MODE_PRE: begin
            effective_address <= mod_addr;
            updated_base      <= mod_addr;
          end
          MODE_OFFSET, MODE_MODULO, MODE_BITREV: begin
            effective_address <= mod_addr;
            updated_base      <= agu_base;
          end
          default: begin
            effective_address <= agu_base;
            updated_base      <= agu_base;
          end
        endcase
      end
    end
  end

  assign stk_start  = (stk_state_reg == ST_IDLE) && (stk_op != STK_NONE);
  assign sp_by_default_work_reg = default_work_reg_we && default_work_reg_sel == `SP_INDEX;
  assign fp_by_default_work_reg = default_work_reg_we && default_work_reg_sel == `FP_INDEX;

  // Stack pointer: stack sequencer, then register writes, then bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_pointer_reg <= `SP_RESET;
    end else if (stk_start || stk_state_reg != ST_IDLE) begin
      if (stk_state_reg == ST_POP_TWO ||
          (stk_state_reg == ST_IDLE && (stk_op == STK_POP || stk_op == STK_RET))) begin
        stack_pointer_reg <= stack_pointer_reg - `WORD_STEP;
      end else begin
        stack_pointer_reg <= stack_pointer_reg + `WORD_STEP;
      end
    end else if (sp_by_default_work_reg) begin
      stack_pointer_reg <= {default_work_reg_wdata[15:1], 1'b0};
    end else if (apb_write && paddr == `OFS_STACK_PTR) begin
      stack_pointer_reg <= {pwdata[15:1], 1'b0};
    end
  end

  // Frame pointer shares the working register write port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_pointer_reg <= `FP_RESET;
    end else if (fp_by_default_work_reg) begin
      frame_pointer_reg <= default_work_reg_wdata;
    end else if (apb_write && paddr == `OFS_FRAME_PTR) begin
      frame_pointer_reg <= pwdata[15:0];
    end
  end

  // Stack sequencer; requests during a two-word frame are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stk_state_reg <= ST_IDLE;
      hold_word_reg <= 16'h0000;
      mem_req       <= 1'b0;
      mem_we        <= 1'b0;
      mem_addr      <= 16'h0000;
      mem_wdata     <= 16'h0000;
      stk_busy      <= 1'b0;
    end else begin
      mem_req  <= 1'b0;
      mem_we   <= 1'b0;
      stk_busy <= 1'b0;
      unique case (stk_state_reg)
        ST_IDLE: begin
          if (stk_start) begin
            mem_req <= 1'b1;
            unique case (stk_op)
              STK_PUSH: begin
                mem_we    <= 1'b1;
                mem_addr  <= stack_pointer_reg;
                mem_wdata <= stk_data;
              end
              STK_CALL, STK_EXC: begin
                mem_we        <= 1'b1;
                mem_addr      <= stack_pointer_reg;
                mem_wdata     <= pc[15:0];
                stk_state_reg <= ST_PUSH_TWO;
                stk_busy      <= 1'b1;
                if (stk_op == STK_EXC) begin
                  hold_word_reg <= {status_low_byte, 1'b0, pc[22:16]};
                end else begin
                  hold_word_reg <= {9'h000, pc[22:16]};
                end
              end
              STK_RET: begin
                mem_addr      <= stack_pointer_reg - `WORD_STEP;
                stk_state_reg <= ST_POP_TWO;
                stk_busy      <= 1'b1;
              end
              default: begin
                mem_addr <= stack_pointer_reg - `WORD_STEP;
              end
            endcase
          end
        end
        ST_PUSH_TWO: begin
          mem_req       <= 1'b1;
          mem_we        <= 1'b1;
          mem_addr      <= stack_pointer_reg;
          mem_wdata     <= hold_word_reg;
          stk_state_reg <= ST_IDLE;
        end
        ST_POP_TWO: begin
          mem_req       <= 1'b1;
          mem_addr      <= stack_pointer_reg - `WORD_STEP;
          stk_state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Operand helpers: near file address and second operand select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      near_addr <= 16'h0000;
      file_wsel <= `WORK_REG_ZERO;
      op2_value <= 16'h0000;
    end else begin
      if (file_req) begin
        near_addr <= {3'b000, file_addr};
        file_wsel <= `WORK_REG_ZERO;
      end
      op2_value <= op2_lit_sel ? {11'h000, op2_lit} : op2_reg_val;
    end
  end

  // Checks
  a_sp_aligned: assert property (@(posedge pclk) disable iff (!presetn)
    stack_pointer_reg[0] == 1'b0) else $error("stack pointer misaligned");

  a_sp_reset_val: assert property (@(posedge pclk)
    $rose(presetn) |-> stack_pointer_reg == `SP_RESET)
    else $error("stack pointer reset value wrong");

  a_push_post_inc: assert property (@(posedge pclk) disable iff (!presetn)
    (stk_start && stk_op == STK_PUSH) |=>
      mem_we && mem_addr == $past(stack_pointer_reg) &&
      stack_pointer_reg == $past(stack_pointer_reg) + `WORD_STEP)
    else $error("push did not write then increment");

  a_call_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (stk_start && stk_op == STK_CALL) |=> mem_wdata == $past(pc[15:0])
      ##1 (mem_we && mem_wdata[15:7] == 9'h000))
    else $error("call frame upper word not zero extended");

  a_exc_status_byte: assert property (@(posedge pclk) disable iff (!presetn)
    (stk_start && stk_op == STK_EXC) |=> ##1 mem_wdata[15:8] == $past(status_low_byte, 2))
    else $error("exception frame lost status low byte");

  a_zero_page_trap: assert property (@(posedge pclk) disable iff (!presetn)
    trap_zero |=> addr_trap && !ea_valid)
    else $error("zero page access not trapped");

  a_psv_write_trap: assert property (@(posedge pclk) disable iff (!presetn)
    (agu_req && paged && agu_write && write_page_reg[`PG_PSV_BIT]) |=>
      addr_trap && $stable(write_page_reg))
    else $error("program space write not trapped");

  a_ovf_page_inc: assert property (@(posedge pclk) disable iff (!presetn)
    (page_upd && !agu_write && ovf && read_page_reg != `PG_EDS_LAST &&
     read_page_reg != `PG_PSV_LOW_LAST && read_page_reg != `PG_PSV_LAST) |=>
      read_page_reg == $past(read_page_reg) + 10'h001 && updated_base[15])
    else $error("read overflow did not advance page");

  a_last_page_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (page_upd && ovf && active_page_reg == `PG_EDS_LAST) |=>
      $stable(read_page_reg) && $stable(write_page_reg) && !updated_base[15])
    else $error("last page overflow not sent to base space");

  a_offset_no_carry: assert property (@(posedge pclk) disable iff (!presetn)
    (agu_req && paged && !linear) |=> $stable(read_page_reg) && $stable(write_page_reg)
      && effective_address[15])
    else $error("offset mode changed the page");

  a_stack_unpaged: assert property (@(posedge pclk) disable iff (!presetn)
    (agu_req && agu_is_stack) |=> $stable(read_page_reg) && $stable(write_page_reg)
      && ea_page == `PG_ZERO)
    else $error("stack pointer access was paged");

  c_page_carry: cover property (@(posedge pclk) disable iff (!presetn)
    page_upd && ovf);
  c_exc_frame: cover property (@(posedge pclk) disable iff (!presetn)
    stk_start && stk_op == STK_EXC ##2 stk_state_reg == ST_IDLE);
  c_trap: cover property (@(posedge pclk) disable iff (!presetn) addr_trap);

endmodule

/* File: verilog/agu_map.svh */
// Offsets, field positions, reset values and page limits of the address generator
// Notes on behaviour
// - Separate read and write page registers allow reading one page, writing another.
// - A paged window overflow or underflow first yields effective address bit 15 clear.
// - Page carry applies only to paged accesses using pre- or post-modified indirect.
// - On overflow the active page increments and address bit 15 is set.
// - On underflow the active page decrements and address bit 15 is set.
// - Offset, modulo and bit-reversed modes set bit 15 and keep the page.
// - Overflow from page 0x1FF or read page 0x3FF keeps page, clears bit 15.
// - Read overflow 0x2FF goes to 0x300; read underflow 0x300 goes to 0x2FF.
// - Read underflow from 0x001 or 0x200 keeps page and clears bit 15.
// - An extended data access with page register zero raises an address trap.
// - Program space is read only; writing it through the write page traps.
// - Register 15 is the stack pointer, auto-updated yet writable like others.
// - Stack pointer bit 0 is always zero for word alignment.
// - Every reset loads the stack pointer with 0x1000.
// - Stack grows upward; push writes then increments, pop decrements then reads.
// - Program counter low word pushed first, upper word next, zero-extended on calls.
// - Exception entry puts the status low byte beside the upper program counter bits.
// - Stack and active frame pointer are never paged, range 0x0000 to 0xFFFF.
// - File register address is 13 bits; register 0 is the default operand.
// - Three-operand ops: register first operand, register or 5-bit literal second.
// - Page plus base address forms the extended address reaching program space.
`ifndef AGU_MAP_SVH
`define AGU_MAP_SVH

`define OFS_READ_PAGE   8'h00
`define OFS_WRITE_PAGE  8'h04
`define OFS_STACK_PTR   8'h08
`define OFS_FRAME_PTR   8'h0C
`define OFS_CONTROL     8'h10
`define OFS_TRAP_STAT   8'h14

`define CTRL_FRAME_BIT  0
`define TRAP_ZERO_BIT   0
`define TRAP_PSW_BIT    1

`define SP_RESET        16'h1000
`define PAGE_RESET      10'h001
`define FP_RESET        16'h0000
`define WORD_STEP       16'h0002

`define PG_EDS_LAST     10'h1FF
`define PG_PSV_FIRST    10'h200
`define PG_PSV_LOW_LAST 10'h2FF
`define PG_PSV_HI_FIRST 10'h300
`define PG_PSV_LAST     10'h3FF
`define PG_FIRST        10'h001
`define PG_ZERO         10'h000
`define PG_PSV_BIT      9

`define SP_INDEX        4'hF
`define FP_INDEX        4'hE
`define WORK_REG_ZERO   4'h0

`endif

/* File: verilog/agu_pkg.sv */
// Types shared by the address generator files
package agu_pkg;

  typedef enum logic [2:0] {
    MODE_DIRECT   = 3'h0,
    MODE_INDIRECT = 3'h1,
    MODE_POST     = 3'h2,
    MODE_PRE      = 3'h3,
    MODE_OFFSET   = 3'h4,
    MODE_MODULO   = 3'h5,
    MODE_BITREV   = 3'h6
  } agu_mode_e;

  typedef enum logic [2:0] {
    STK_NONE = 3'h0,
    STK_PUSH = 3'h1,
    STK_POP  = 3'h2,
    STK_CALL = 3'h3,
    STK_EXC  = 3'h4,
    STK_RET  = 3'h5
  } stk_op_e;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b001,
    ST_PUSH_TWO = 3'b010,
    ST_POP_TWO  = 3'b100
  } stk_state_e;

endpackage

/* File: verilog/page_boundary_fix.sv */
// Page carry and bit 15 correction for one paged address calculation
`include "agu_map.svh"

module page_boundary_fix (
  input  wire logic [9:0]  page,
  input  wire logic [16:0] sum,
  input  wire logic        offset_neg,
  input  wire logic        is_write,
  input  wire logic        linear,
  output logic [9:0]       new_page,
  output logic             ea15,
  output logic             ovf,
  output logic             udf
);

  // A base inside the window leaving it shows as bit 15 clear
  assign ovf = ~sum[15] & ~offset_neg;
  assign udf = ~sum[15] & offset_neg;

  // Boundary table first, then the generic carry
  always_comb begin
    new_page = page;
    ea15     = 1'b1;
    if (!linear) begin
      ea15 = 1'b1;
    end else if (ovf) begin
      if (page == `PG_EDS_LAST || (!is_write && page == `PG_PSV_LAST)) begin
        ea15 = 1'b0;
      end else if (!is_write && page == `PG_PSV_LOW_LAST) begin
        new_page = `PG_PSV_HI_FIRST;
      end else begin
        new_page = page + 10'h001;
      end
    end else if (udf) begin
      if (page == `PG_FIRST || (!is_write && page == `PG_PSV_FIRST)) begin
        ea15 = 1'b0;
      end else if (!is_write && page == `PG_PSV_HI_FIRST) begin
        new_page = `PG_PSV_LOW_LAST;
      end else begin
        new_page = page - 10'h001;
      end
    end
  end

endmodule

/* File: tb/stack_mem_model.sv */
// Data memory model that keeps the words the stack sequencer writes
module stack_mem_model (
  input wire logic        pclk,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] mem [0:32767];

  // Word store; address bit 0 is dropped because stack words are aligned
  always @(posedge pclk) begin
    if (mem_req && mem_we) begin
      mem[mem_addr[15:1]] <= mem_wdata;
    end
  end
endmodule

/* File: tb/paged_address_and_stack_agu_tb_top.sv */
// Self-checking bench for the paged address generator and stack pointer
`include "agu_map.svh"
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); end end

module paged_address_and_stack_agu_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import agu_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0]  paddr, status_low_byte;
  logic [31:0] pwdata, prdata, rdata, seed, r, p;
  logic        agu_req, agu_write, agu_is_stack, agu_is_frame, ea_valid, addr_trap;
  agu_mode_e   agu_mode;
  stk_op_e     stk_op;
  logic [15:0] agu_base, agu_offset, effective_address, updated_base, sp0, d;
  logic [9:0]  ea_page;
  logic        default_work_reg_we, mem_req, mem_we, stk_busy, file_req, op2_lit_sel;
  logic [3:0]  default_work_reg_sel, file_wsel;
  logic [15:0] default_work_reg_wdata, stack_pointer_reg, stk_data, mem_addr, mem_wdata;
  logic [15:0] near_addr, op2_reg_val, op2_value;
  logic [22:0] pc;
  logic [12:0] file_addr;
  logic [4:0]  op2_lit;
  int          num_errors, comparisons;

  paged_address_and_stack_agu dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .agu_req(agu_req), .agu_write(agu_write), .agu_mode(agu_mode), .agu_base(agu_base),
    .agu_offset(agu_offset), .agu_is_stack(agu_is_stack), .agu_is_frame(agu_is_frame),
    .ea_valid(ea_valid), .effective_address(effective_address), .updated_base(updated_base),
    .ea_page(ea_page), .addr_trap(addr_trap), .default_work_reg_we(default_work_reg_we), .default_work_reg_sel(default_work_reg_sel),
    .default_work_reg_wdata(default_work_reg_wdata), .stack_pointer_reg(stack_pointer_reg), .stk_op(stk_op),
    .stk_data(stk_data), .pc(pc), .status_low_byte(status_low_byte), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .stk_busy(stk_busy),
    .file_req(file_req), .file_addr(file_addr), .near_addr(near_addr),
    .file_wsel(file_wsel), .op2_lit_sel(op2_lit_sel), .op2_lit(op2_lit),
    .op2_reg_val(op2_reg_val), .op2_value(op2_value));

  stack_mem_model mem_u (.pclk(pclk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, far beyond what the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    report_and_stop;
  end

  // One APB transfer; waits for pready, then idles one cycle
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rerr = pslverr;
    if (n >= 50) num_errors++;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  // One address request; returns when its registered answer is visible
  task agu(input logic w, input agu_mode_e m, input logic [15:0] b, input logic [15:0] o,
           input logic st);
    agu_req <= 1'b1; agu_write <= w; agu_mode <= m; agu_base <= b; agu_offset <= o;
    agu_is_stack <= st;
    @(posedge pclk);
    agu_req <= 1'b0;
    @(posedge pclk);
  endtask

  // Expected {page, address} after carry; lin set selects the wrap-in-page modes
  function automatic logic [25:0] exp_fix(input logic [9:0] pg, input logic [15:0] b,
                                          input logic [15:0] o, input logic lin);
    logic [15:0] s;
    s = b + o;
    if (s[15]) return {pg, s};
    if (lin) return {pg, 1'b1, s[14:0]};
    if (!o[15]) begin
      if (pg == `PG_EDS_LAST || pg == `PG_PSV_LAST) return {pg, 1'b0, s[14:0]};
      return {pg + 10'h001, 1'b1, s[14:0]};
    end
    if (pg == `PG_FIRST || pg == `PG_PSV_FIRST) return {pg, 1'b0, s[14:0]};
    return {pg - 10'h001, 1'b1, s[14:0]};
  endfunction

  // Boundary case: load page, cross the page edge by one word, check page, and address in pre-modified and offset modes
  task run_case(input logic w, input logic [9:0] pg, input logic [15:0] o, input agu_mode_e m);
    logic [25:0] x;
    logic [15:0] b;
    b = o[15] ? 16'h8000 : 16'hFFFE;
    x = exp_fix(pg, b, o, m != MODE_PRE);
    apb(1'b1, w ? `OFS_WRITE_PAGE : `OFS_READ_PAGE, {22'h0, pg});
    agu(w, m, b, o, 1'b0);
    `CHK(ea_valid, 1'b1)
    `CHK(ea_page, pg)
    if (m == MODE_PRE) `CHK(updated_base, x[15:0])
    if (m == MODE_PRE || m == MODE_OFFSET) `CHK(effective_address, x[15:0])
    apb(1'b0, w ? `OFS_WRITE_PAGE : `OFS_READ_PAGE, 32'h0);
    `CHK(rdata[9:0], x[25:16])
  endtask

  initial begin
    seed = 32'h16A8;
    num_errors = 0; comparisons = 0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    agu_req = 1'b0; agu_write = 1'b0; agu_mode = MODE_DIRECT; agu_base = 16'h0;
    agu_offset = 16'h0; agu_is_stack = 1'b0; agu_is_frame = 1'b0;
    default_work_reg_we = 1'b0; default_work_reg_sel = 4'h0; default_work_reg_wdata = 16'h0; stk_op = STK_NONE;
    stk_data = 16'h0; pc = 23'h0; status_low_byte = 8'h00; file_req = 1'b0;
    file_addr = 13'h0; op2_lit_sel = 1'b0; op2_lit = 5'h00; op2_reg_val = 16'h0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    `CHK(stack_pointer_reg, `SP_RESET)
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h40, 32'h0);
    `CHK(rerr, 1'b1)
    apb(1'b1, `OFS_STACK_PTR, 32'h2345);
    apb(1'b0, `OFS_STACK_PTR, 32'h0);
    `CHK(rdata[15:0], 16'h2344)
    default_work_reg_we <= 1'b1; default_work_reg_sel <= `SP_INDEX; default_work_reg_wdata <= 16'h3001;
    @(posedge pclk);
    default_work_reg_we <= 1'b0;
    @(posedge pclk);
    `CHK(stack_pointer_reg, 16'h3000)
    run_case(1'b1, 10'h1FF, 16'h0002, MODE_PRE);
    run_case(1'b0, 10'h1FF, 16'h0002, MODE_PRE);
    run_case(1'b0, 10'h2FF, 16'h0002, MODE_PRE);
    run_case(1'b0, 10'h3FF, 16'h0002, MODE_PRE);
    run_case(1'b0, 10'h001, 16'hFFFE, MODE_PRE);
    run_case(1'b0, 10'h200, 16'hFFFE, MODE_PRE);
    run_case(1'b0, 10'h300, 16'hFFFE, MODE_PRE);
    run_case(1'b0, 10'h050, 16'h0002, MODE_PRE);
    run_case(1'b0, 10'h050, 16'hFFFE, MODE_PRE);
    run_case(1'b0, 10'h050, 16'h0002, MODE_OFFSET);
    run_case(1'b0, 10'h050, 16'h0002, MODE_MODULO);
    run_case(1'b0, 10'h050, 16'hFFFE, MODE_BITREV);
    apb(1'b0, `OFS_WRITE_PAGE, 32'h0);
    `CHK(rdata[9:0], 10'h1FF)
    apb(1'b1, `OFS_READ_PAGE, 32'h0);
    agu(1'b0, MODE_PRE, 16'h9000, 16'h0002, 1'b0);
    `CHK(addr_trap, 1'b1)
    apb(1'b1, `OFS_WRITE_PAGE, {22'h0, `PG_PSV_FIRST});
    agu(1'b1, MODE_PRE, 16'h9000, 16'h0002, 1'b0);
    `CHK(addr_trap, 1'b1)
    apb(1'b0, `OFS_TRAP_STAT, 32'h0);
    `CHK(rdata[1:0], 2'b11)
    agu(1'b0, MODE_PRE, 16'hFFFE, 16'h0002, 1'b1);
    `CHK(effective_address, 16'h0000)
    `CHK(ea_page, `PG_ZERO)
    // Active frame pointer on page zero must neither trap nor page
    apb(1'b1, `OFS_CONTROL, 32'h1);
    agu_is_frame <= 1'b1;
    agu(1'b0, MODE_PRE, 16'hFFFE, 16'h0002, 1'b0);
    `CHK(addr_trap, 1'b0)
    `CHK(ea_valid, 1'b1)
    // Calls and exception entries alternate, with random program counter and status
    for (int i = 0; i < 4; i++) begin
      sp0 = stack_pointer_reg;
      p = $random(seed);
      r = $random(seed);
      if (i % 2 == 1) stk_op <= STK_EXC;
      else stk_op <= STK_CALL;
      pc <= p[22:0]; status_low_byte <= r[7:0];
      d = (i % 2 == 1) ? {r[7:0], 1'b0, p[22:16]} : {9'h0, p[22:16]};
      @(posedge pclk);
      stk_op <= STK_NONE;
      @(posedge pclk);
      `CHK(stk_busy, 1'b1)
      repeat (3) @(posedge pclk);
      `CHK(stack_pointer_reg, sp0 + 16'h0004)
      `CHK(mem_u.mem[sp0[15:1]], p[15:0])
      `CHK(mem_u.mem[sp0[15:1] + 15'h1], d)
    end
    sp0 = stack_pointer_reg;
    stk_op <= STK_RET;
    @(posedge pclk);
    stk_op <= STK_NONE;
    repeat (4) @(posedge pclk);
    `CHK(mem_addr, sp0 - 16'h0004)
    d = $random(seed);
    stk_op <= STK_PUSH; stk_data <= d;
    @(posedge pclk);
    stk_op <= STK_POP;
    @(posedge pclk);
    stk_op <= STK_NONE;
    repeat (3) @(posedge pclk);
    `CHK(mem_u.mem[sp0[15:1] - 15'h2], d)
    `CHK(stack_pointer_reg, sp0 - 16'h0004)
    // Random near addresses and second operands
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      file_req <= 1'b1; file_addr <= r[12:0]; op2_lit_sel <= r[13];
      op2_lit <= r[20:16]; op2_reg_val <= r[31:16];
      @(posedge pclk);
      file_req <= 1'b0;
      @(posedge pclk);
      `CHK(near_addr, {3'h0, r[12:0]})
      `CHK(file_wsel, `WORK_REG_ZERO)
      `CHK(op2_value, r[13] ? {11'h0, r[20:16]} : r[31:16])
    end
    // Mid-run reset must reload the stack pointer
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK(stack_pointer_reg, `SP_RESET)
    presetn <= 1'b1;
    @(posedge pclk);
    report_and_stop;
  end
endmodule
